// ==== rtl/ulms_pkg.sv ====
// Constants for the line status and modem control block.
// Assumes a byte-wide CPU port with a three-bit register select.
package ulms_pkg;
    localparam logic [2:0] ADDR_RX_BUF = 3'h0;
    localparam logic [2:0] ADDR_TX_HOLD = 3'h0;
    localparam logic [2:0] ADDR_IRQ_EN = 3'h1;
    localparam logic [2:0] ADDR_IRQ_ID = 3'h2;
    localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
    localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
    localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;
    // Line control fields
    localparam int LC_WLEN_LO = 0;
    localparam int LC_PAR_EN = 3;
    localparam int LC_EVEN_PAR = 4;
    localparam int LC_STICK = 5;
    localparam int LC_BREAK = 6;
    localparam int LC_DLAB = 7;
    // Interrupt enable fields
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_USER1 = 2;
    localparam int MC_USER2 = 3;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] MC_MASK = 8'h1f;
    // Identification codes, bit 0 low means pending
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RX_DATA = 4'h4;
    localparam logic [3:0] ID_TX_EMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;
    // Receive word: {break, stop, parity, data}
    localparam int RXW_WIDTH = 11;
    localparam int RXW_DATA_W = 8;
    localparam int RXW_PAR = 8;
    localparam int RXW_STOP = 9;
    localparam int RXW_BRK = 10;
    localparam int RX_FIFO_DEPTH = 16;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] RST_STAT = 4'h0;
endpackage : ulms_pkg

// ==== rtl/ulms_top.sv ====
// Line status, modem control and modem status section of a serial controller, with its receive FIFO.
// Assumes external shift engines: the receiver pushes whole characters with their parity, stop and
// break sampling; the transmitter takes characters and reports when its shift register is busy.
// Function
// - Received character loaded into buffer sets data-available; buffer read clears it.
// - New character over an unread one sets overrun and overwrites it.
// - Parity mismatch against selected odd or even parity sets parity error.
// - Stop bit sampled low sets framing error.
// - Input spacing longer than one character time sets break flag.
// - Line status read clears overrun, parity, framing and break only.
// - Enabled line errors raise the highest priority interrupt.
// - Holding empty sets on move to shifter, clears on write, not on status read.
// - Enabled holding empty raises priority three interrupt, cleared by identification read.
// - All-empty high only while holder and shifter empty; low until character leaves.
// - Status read leaves all-empty alone; line status bit seven reads zero.
// - Modem control bits zero to three drive their pins inverted.
// - Modem control readable and writable; bits five to seven read zero.
// - Loopback holds serial output marking and feeds transmit data into receiver.
// - Loopback disconnects modem inputs, uses control bits, forces output pins high.
// - Loopback keeps all interrupts working; modem interrupts come from control bits.
// - Clear-to-send, data-set-ready and carrier changes set deltas; status read clears.
// - Ring trailing edge flag sets only when ring input goes low to high.
// - Status bits four to seven show inverted modem input pins.
// - Enabled modem change raises priority four interrupt and identification code.
// - In loopback, status bit four follows request-to-send control bit.
// - Break character is loaded and sets data-available like any character.
// - Error flags set when the character is loaded into the buffer and persist over clean characters.
// - In loopback, status bits five to seven follow DTR, user 1, user 2.
// - Modem deltas arising during their status read set only at the read's trailing edge; line errors wait in the FIFO and set one cycle after it.
`timescale 1ns/10ps
`default_nettype none

module ulms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r;
    logic space_r, empty_r;
    logic push, pop;
    logic [AW:0] cnt_nxt;

    assign push = in_valid && space_r;
    assign pop = !empty_r && out_ready;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = space_r;
    assign out_valid = !empty_r;
    assign out_data = mem[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            space_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            space_r <= (cnt_nxt != (AW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end
endmodule : ulms_fifo

module ulms_top
    import ulms_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CS,
    input wire logic [2:0] ADDR,
    input wire logic RD,
    input wire logic WR,
    input wire logic [7:0] DIN,
    output logic [7:0] DOUT,
    input wire logic RX_CHAR_VALID,
    input wire logic [RXW_WIDTH-1:0] RX_CHAR_WORD,
    output logic RX_READY,
    output logic TX_CHAR_VALID,
    output logic [7:0] TX_CHAR,
    input wire logic TX_CHAR_TAKE,
    input wire logic TX_SHIFT_BUSY,
    input wire logic TX_SHIFT_BIT,
    output logic RX_SERIAL_IN,
    input wire logic SERIAL_RX_PIN,
    output logic SERIAL_TX_PIN,
    output logic [7:0] LINE_CTL,
    input wire logic CTS_N,
    input wire logic DSR_N,
    input wire logic RI_N,
    input wire logic DCD_N,
    output logic DTR_N,
    output logic RTS_N,
    output logic USER_OUTPUT_1_N,
    output logic USER_OUTPUT_2_N,
    output logic IRQ_OUT
);
    function automatic logic [3:0] irq_code(input logic [3:0] ie, input logic line, input logic data,
                                             input logic txe, input logic mdm);
        if (ie[IE_LINE] && line) irq_code = ID_LINE;
        else if (ie[IE_RX_DATA] && data) irq_code = ID_RX_DATA;
        else if (ie[IE_TX_EMPTY] && txe) irq_code = ID_TX_EMPTY;
        else if (ie[IE_MODEM] && mdm) irq_code = ID_MODEM;
        else irq_code = ID_NONE;
    endfunction : irq_code

    function automatic logic is_reg(input logic [2:0] a, input logic [2:0] r);
        is_reg = (a == r);
    endfunction : is_reg

    logic [7:0] rx_buf_r, tx_hold_r, line_ctl_r, mc_r, scratch_r, dout_r;
    logic [3:0] irq_en_r, err_r, delta_r, delta_pend_r, stat_r, id_lat_r;
    logic data_avail_r, tx_empty_r, all_empty_r, txe_irq_r, irq_r, tx_valid_r;
    logic rd_act_r, wr_act_r;
    logic [2:0] rd_addr_r;
    logic tx_pin_r, rx_in_r, dtr_r, rts_r, u1_r, u2_r;

    logic rd_now, rd_start, rd_trail, wr_start, dlab;
    logic rd_line_busy, rd_mstat_busy, line_trail, mstat_trail, rxbuf_trail, id_trail;
    logic wr_tx_hold;
    logic fifo_valid, fifo_ready, pop;
    logic [RXW_WIDTH-1:0] fifo_word;
    logic [7:0] wmask, rx_data;
    logic par_bad;
    logic [3:0] ev_err, stat_nxt, ev_delta;
    logic [3:0] cur_id;

    assign rd_now = CS && RD;
    assign rd_start = rd_now && !rd_act_r;
    assign rd_trail = rd_act_r && !rd_now;
    assign wr_start = CS && WR && !wr_act_r;
    assign dlab = line_ctl_r[LC_DLAB];
    assign rd_line_busy = rd_act_r && is_reg(rd_addr_r, ADDR_LINE_STAT);
    assign rd_mstat_busy = rd_act_r && is_reg(rd_addr_r, ADDR_MODEM_STAT);
    assign line_trail = rd_trail && is_reg(rd_addr_r, ADDR_LINE_STAT);
    assign mstat_trail = rd_trail && is_reg(rd_addr_r, ADDR_MODEM_STAT);
    assign rxbuf_trail = rd_trail && is_reg(rd_addr_r, ADDR_RX_BUF) && !dlab;
    assign id_trail = rd_trail && is_reg(rd_addr_r, ADDR_IRQ_ID);
    assign wr_tx_hold = wr_start && is_reg(ADDR, ADDR_TX_HOLD) && !dlab;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            rd_addr_r <= 3'h0;
        end else begin
            rd_act_r <= rd_now;
            wr_act_r <= CS && WR;
            if (rd_start) begin
                rd_addr_r <= ADDR;
            end
        end
    end

    // Drain stalls during a line status read, so no error can land mid-read
    ulms_fifo #(.WIDTH(RXW_WIDTH), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_valid(RX_CHAR_VALID),
        .in_ready(RX_READY),
        .in_data(RX_CHAR_WORD),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_word)
    );
    assign fifo_ready = !rd_line_busy && !(rd_now && is_reg(ADDR, ADDR_LINE_STAT));
    assign pop = fifo_valid && fifo_ready;

    always_comb begin
        wmask = 8'h1f;
        case (line_ctl_r[LC_WLEN_LO +: 2])
            2'h1: wmask = 8'h3f;
            2'h2: wmask = 8'h7f;
            2'h3: wmask = 8'hff;
            default: wmask = 8'h1f;
        endcase
    end
    assign rx_data = fifo_word[RXW_DATA_W-1:0] & wmask;
    // Stick parity expects the inverse of the even select bit
    assign par_bad = line_ctl_r[LC_PAR_EN] && (line_ctl_r[LC_STICK] ?
                     (fifo_word[RXW_PAR] != !line_ctl_r[LC_EVEN_PAR]) :
                     ((^{rx_data, fifo_word[RXW_PAR]}) != !line_ctl_r[LC_EVEN_PAR]));
    assign ev_err = {pop && fifo_word[RXW_BRK],
                     pop && !fifo_word[RXW_STOP],
                     pop && par_bad,
                     pop && data_avail_r && !rxbuf_trail};

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rx_buf_r <= RST_ZERO;
            data_avail_r <= 1'b0;
        end else begin
            if (pop) begin
                rx_buf_r <= rx_data;
            end
            data_avail_r <= pop || (data_avail_r && !rxbuf_trail);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            err_r <= RST_STAT;
        end else if (line_trail) begin
            err_r <= ev_err;
        end else begin
            err_r <= err_r | ev_err;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tx_hold_r <= RST_ZERO;
            tx_empty_r <= 1'b1;
            all_empty_r <= 1'b1;
            tx_valid_r <= 1'b0;
        end else begin
            if (wr_tx_hold) begin
                tx_hold_r <= DIN;
            end
            tx_empty_r <= !wr_tx_hold && (TX_CHAR_TAKE || tx_empty_r);
            tx_valid_r <= wr_tx_hold || !(TX_CHAR_TAKE || tx_empty_r);
            all_empty_r <= !wr_tx_hold && !TX_CHAR_TAKE && !TX_SHIFT_BUSY
                           && (TX_CHAR_TAKE || tx_empty_r);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            line_ctl_r <= RST_ZERO;
            irq_en_r <= RST_STAT;
            mc_r <= RST_ZERO;
            scratch_r <= RST_ZERO;
        end else if (wr_start) begin
            if (is_reg(ADDR, ADDR_LINE_CTL)) line_ctl_r <= DIN;
            if (is_reg(ADDR, ADDR_IRQ_EN) && !dlab) irq_en_r <= DIN[3:0];
            if (is_reg(ADDR, ADDR_MODEM_CTL)) mc_r <= DIN & MC_MASK;
            if (is_reg(ADDR, ADDR_SCRATCH)) scratch_r <= DIN;
        end
    end

    // Status order {carrier, ring, set ready, clear to send}
    assign stat_nxt = mc_r[MC_LOOP] ? {mc_r[MC_USER2], mc_r[MC_USER1], mc_r[MC_DTR], mc_r[MC_RTS]}
                                    : {!DCD_N, !RI_N, !DSR_N, !CTS_N};
    assign ev_delta = {stat_nxt[3] ^ stat_r[3],
                       stat_r[2] && !stat_nxt[2],
                       stat_nxt[1] ^ stat_r[1],
                       stat_nxt[0] ^ stat_r[0]};

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            stat_r <= RST_STAT;
            delta_r <= RST_STAT;
            delta_pend_r <= RST_STAT;
        end else begin
            stat_r <= stat_nxt;
            if (mstat_trail) begin
                delta_r <= delta_pend_r | ev_delta;
                delta_pend_r <= RST_STAT;
            end else if (rd_mstat_busy || (rd_start && is_reg(ADDR, ADDR_MODEM_STAT))) begin
                delta_pend_r <= delta_pend_r | (ev_delta & ~delta_r);
            end else begin
                delta_r <= delta_r | ev_delta;
            end
        end
    end

    assign cur_id = irq_code(irq_en_r, |err_r, data_avail_r, txe_irq_r, |delta_r);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            txe_irq_r <= 1'b0;
            id_lat_r <= ID_NONE;
            irq_r <= 1'b0;
        end else begin
            if (rd_start) begin
                id_lat_r <= cur_id;
            end
            // Raised on the move to the shifter; a fresh event beats the clearing read
            if (TX_CHAR_TAKE) begin
                txe_irq_r <= 1'b1;
            end else if (wr_tx_hold || (id_trail && id_lat_r == ID_TX_EMPTY)) begin
                txe_irq_r <= 1'b0;
            end
            irq_r <= (cur_id != ID_NONE);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dout_r <= RST_ZERO;
        end else if (rd_start) begin
            case (ADDR)
                ADDR_RX_BUF: dout_r <= dlab ? RST_ZERO : rx_buf_r;
                ADDR_IRQ_EN: dout_r <= dlab ? RST_ZERO : {4'h0, irq_en_r};
                ADDR_IRQ_ID: dout_r <= {4'h0, cur_id};
                ADDR_LINE_CTL: dout_r <= line_ctl_r;
                ADDR_MODEM_CTL: dout_r <= mc_r;
                ADDR_LINE_STAT: dout_r <= {1'b0, all_empty_r, tx_empty_r, err_r, data_avail_r};
                ADDR_MODEM_STAT: dout_r <= {stat_r, delta_r};
                ADDR_SCRATCH: dout_r <= scratch_r;
                default: dout_r <= RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tx_pin_r <= 1'b1;
            rx_in_r <= 1'b1;
            dtr_r <= 1'b1;
            rts_r <= 1'b1;
            u1_r <= 1'b1;
            u2_r <= 1'b1;
        end else begin
            tx_pin_r <= mc_r[MC_LOOP] || (!line_ctl_r[LC_BREAK] && TX_SHIFT_BIT);
            rx_in_r <= mc_r[MC_LOOP] ? TX_SHIFT_BIT : SERIAL_RX_PIN;
            dtr_r <= mc_r[MC_LOOP] || !mc_r[MC_DTR];
            rts_r <= mc_r[MC_LOOP] || !mc_r[MC_RTS];
            u1_r <= mc_r[MC_LOOP] || !mc_r[MC_USER1];
            u2_r <= mc_r[MC_LOOP] || !mc_r[MC_USER2];
        end
    end

    assign DOUT = dout_r;
    assign TX_CHAR_VALID = tx_valid_r;
    assign TX_CHAR = tx_hold_r;
    assign LINE_CTL = line_ctl_r;
    assign SERIAL_TX_PIN = tx_pin_r;
    assign RX_SERIAL_IN = rx_in_r;
    assign DTR_N = dtr_r;
    assign RTS_N = rts_r;
    assign USER_OUTPUT_1_N = u1_r;
    assign USER_OUTPUT_2_N = u2_r;
    assign IRQ_OUT = irq_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    chk_dr_after_pop: assert property (pop |=> data_avail_r)
        else $error("data available not set after load");
    chk_overrun_set: assert property (pop && data_avail_r && !rxbuf_trail |=> err_r[0])
        else $error("overrun not flagged");
    chk_lsr_clear: assert property (line_trail |=> err_r == 4'h0)
        else $error("line errors not cleared by status read");
    chk_err_sticky: assert property (!line_trail && |err_r |=> |err_r)
        else $error("error flag dropped without read");
    chk_hold_write: assert property (wr_tx_hold |=> !tx_empty_r && !all_empty_r)
        else $error("empty flags not cleared by write");
    chk_tx_all_empty_tx_holding_empty: assert property (all_empty_r |-> tx_empty_r)
        else $error("all empty without holding empty");
    chk_loop_mark: assert property (mc_r[MC_LOOP] |=> SERIAL_TX_PIN && DTR_N && RTS_N && USER_OUTPUT_2_N)
        else $error("loopback pins not inactive");
    chk_loop_cts: assert property (mc_r[MC_LOOP] && $stable(mc_r) |=> stat_r[0] == $past(mc_r[MC_RTS]))
        else $error("loopback clear to send wrong");
    chk_dtr_pin: assert property (!mc_r[MC_LOOP] && $stable(mc_r) |=> DTR_N == !$past(mc_r[MC_DTR]))
        else $error("terminal ready pin polarity wrong");
    chk_line_irq: assert property (irq_en_r[IE_LINE] && |err_r |=> IRQ_OUT)
        else $error("line status interrupt missing");
    cov_overrun: cover property (pop && data_avail_r);
    cov_loop_delta: cover property (mc_r[MC_LOOP] ##1 (|ev_delta));
    cov_fifo_full: cover property (!RX_READY);
    cov_id_read_tx: cover property (id_trail && id_lat_r == ID_TX_EMPTY);
endmodule : ulms_top

`default_nettype wire

// ==== testbench/ulms_modem_model.sv ====
// Far-side partner: modem handshake lines and a transmit shift engine.
// Assumes the bench steers the modem pin levels and may stall character take-up.
`timescale 1ns/10ps
`default_nettype none
module ulms_modem_model #(
    parameter int SHIFT_LEN = 30
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lines,
    input wire logic stall,
    input wire logic tx_valid,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic dcd_n,
    output logic take,
    output logic busy,
    output logic shift_bit
);
    int cnt_r;
    always_ff @(posedge clk) begin
        if (!rst_n) {dcd_n, ri_n, dsr_n, cts_n} <= 4'hf;
        else {dcd_n, ri_n, dsr_n, cts_n} <= lines;
    end
    // Shifter toggles while busy so a stale bit never passes for a live one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            take <= 1'b0;
            busy <= 1'b0;
            shift_bit <= 1'b1;
            cnt_r <= 0;
        end else begin
            take <= 1'b0;
            if (busy) begin
                cnt_r <= cnt_r - 1;
                shift_bit <= ~shift_bit;
                if (cnt_r == 1) begin
                    busy <= 1'b0;
                    shift_bit <= 1'b1;
                end
            end else if (take) begin
                busy <= 1'b1;
                cnt_r <= SHIFT_LEN;
                shift_bit <= 1'b0;
            end else if (tx_valid && !stall) begin
                take <= 1'b1;
            end
        end
    end
endmodule : ulms_modem_model
`default_nettype wire

// ==== testbench/ulms_top_tb.sv ====
// Self-checking bench for the line status and modem control block.
// Assumes the bench plays the receive engine and the CPU; the partner model plays modem and shifter.
`timescale 1ns/10ps
`default_nettype none
module ulms_top_tb import ulms_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, rd = 1'b0, wr = 1'b0, rxv = 1'b0, srx = 1'b1, stall = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] din = 8'h00, dout, txc, lctl, v;
    logic [10:0] rxw = 11'h000;
    logic [3:0] lines = 4'hf;
    logic rxr, txv, take, busy, sbit, rsi, stx, cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, u1_n, u2_n, irq;
    int failures = 0, num_checks = 0, n, k, i;
    logic [10:0] ew [3] = '{11'h201, 11'h003, 11'h400};
    logic [7:0] el [3] = '{8'h65, 8'h69, 8'h79};
    logic [7:0] ed [3] = '{8'h01, 8'h03, 8'h00};

    ulms_top ulms_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .CS(cs), .ADDR(addr), .RD(rd), .WR(wr),
        .DIN(din), .DOUT(dout), .RX_CHAR_VALID(rxv), .RX_CHAR_WORD(rxw), .RX_READY(rxr),
        .TX_CHAR_VALID(txv), .TX_CHAR(txc), .TX_CHAR_TAKE(take), .TX_SHIFT_BUSY(busy),
        .TX_SHIFT_BIT(sbit), .RX_SERIAL_IN(rsi), .SERIAL_RX_PIN(srx), .SERIAL_TX_PIN(stx),
        .LINE_CTL(lctl), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n), .DTR_N(dtr_n),
        .RTS_N(rts_n), .USER_OUTPUT_1_N(u1_n), .USER_OUTPUT_2_N(u2_n), .IRQ_OUT(irq));
    ulms_modem_model ulms_modem_model_inst (.clk(clk), .rst_n(rst_n), .lines(lines), .stall(stall),
        .tx_valid(txv), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .take(take),
        .busy(busy), .shift_bit(sbit));

    always #2 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk); cs <= 1'b1; wr <= 1'b1; addr <= a; din <= d;
        @(posedge clk); cs <= 1'b0; wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    // Clear-on-read lands at the trailing edge; two idle edges let the interrupt settle
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk); cs <= 1'b1; rd <= 1'b1; addr <= a;
        @(posedge clk); cs <= 1'b0; rd <= 1'b0;
        @(posedge clk); d = dout;
        repeat (2) @(posedge clk);
    endtask : rd_reg
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask : rdchk
    task automatic push(input logic [10:0] w);
        int m;
        @(posedge clk); rxv <= 1'b1; rxw <= w;
        m = 0;
        do begin @(posedge clk); m++; end while (rxr !== 1'b1 && m < 50);
        if (m >= 50) begin failures++; end_sim(); end
        rxv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : push
    task automatic wait_busy(input logic lvl);
        int m;
        m = 0;
        while (busy !== lvl && m < 200) begin @(posedge clk); m++; end
        if (m >= 200) begin failures++; end_sim(); end
    endtask : wait_busy
    task automatic set_lines(input logic [3:0] l);
        @(posedge clk); lines <= l;
        repeat (4) @(posedge clk);
    endtask : set_lines

    initial begin
        #200000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(ADDR_LINE_STAT, 8'h60);
        rdchk(ADDR_MODEM_CTL, 8'h00);
        rdchk(ADDR_MODEM_STAT, 8'h00);
        chk({3'h0, stx, dtr_n, rts_n, u1_n, u2_n}, 8'h1f);
        chk({7'h0, irq}, 8'h00);
        // Modem control bits and their inverted pins
        for (i = 0; i < 2; i++) begin
            v = (i == 0) ? 8'he5 : 8'h0a;
            wr_reg(ADDR_MODEM_CTL, v);
            rdchk(ADDR_MODEM_CTL, v & 8'h0f);
            chk({4'h0, u2_n, u1_n, rts_n, dtr_n}, {4'h0, ~v[3:0]});
        end
        wr_reg(ADDR_MODEM_CTL, 8'h00);
        wr_reg(ADDR_LINE_CTL, 8'h1b);
        chk(lctl, 8'h1b);
        wr_reg(ADDR_IRQ_EN, 8'h04);
        // Parity, framing and break characters in turn
        for (i = 0; i < 3; i++) begin
            push(ew[i]);
            chk({7'h0, irq}, 8'h01);
            rdchk(ADDR_IRQ_ID, {4'h0, ID_LINE});
            rdchk(ADDR_LINE_STAT, el[i]);
            chk({7'h0, irq}, 8'h00);
            rdchk(ADDR_RX_BUF, ed[i]);
        end
        push(ew[0]);
        rdchk(ADDR_RX_BUF, 8'h01);
        push(11'h203);
        rdchk(ADDR_LINE_STAT, 8'h65);
        rdchk(ADDR_RX_BUF, 8'h03);
        rdchk(ADDR_LINE_STAT, 8'h60);
        // Held status read stalls the drain so the FIFO fills
        @(posedge clk); cs <= 1'b1; rd <= 1'b1; addr <= ADDR_LINE_STAT; rxv <= 1'b1; rxw <= 11'h200;
        k = 0;
        repeat (24) begin
            @(posedge clk);
            if (rxr === 1'b1) begin k++; rxw <= 11'h200 | 11'(k); end
        end
        chk(8'(k), 8'(RX_FIFO_DEPTH));
        chk({7'h0, rxr}, 8'h00);
        rxv <= 1'b0; cs <= 1'b0; rd <= 1'b0;
        repeat (40) @(posedge clk);
        rdchk(ADDR_LINE_STAT, 8'h67);
        rdchk(ADDR_RX_BUF, 8'h0f);
        rdchk(ADDR_LINE_STAT, 8'h60);
        // Transmit empties and their interrupt
        wr_reg(ADDR_IRQ_EN, 8'h00);
        stall <= 1'b1;
        wr_reg(ADDR_TX_HOLD, 8'h55);
        chk(txc, 8'h55);
        rdchk(ADDR_LINE_STAT, 8'h00);
        wr_reg(ADDR_IRQ_EN, 8'h02);
        stall <= 1'b0;
        wait_busy(1'b1);
        rdchk(ADDR_LINE_STAT, 8'h20);
        chk({7'h0, irq}, 8'h01);
        rdchk(ADDR_IRQ_ID, {4'h0, ID_TX_EMPTY});
        chk({7'h0, irq}, 8'h00);
        wait_busy(1'b0);
        repeat (2) @(posedge clk);
        rdchk(ADDR_LINE_STAT, 8'h60);
        rdchk(ADDR_LINE_STAT, 8'h60);
        // Modem status deltas, levels and interrupt
        wr_reg(ADDR_IRQ_EN, 8'h08);
        set_lines(4'b1110);
        chk({7'h0, irq}, 8'h01);
        rdchk(ADDR_IRQ_ID, {4'h0, ID_MODEM});
        rdchk(ADDR_MODEM_STAT, 8'h11);
        rdchk(ADDR_MODEM_STAT, 8'h10);
        chk({7'h0, irq}, 8'h00);
        set_lines(4'b1010);
        rdchk(ADDR_MODEM_STAT, 8'h50);
        set_lines(4'b1110);
        rdchk(ADDR_MODEM_STAT, 8'h14);
        set_lines(4'b0100);
        rdchk(ADDR_MODEM_STAT, 8'hba);
        // Loopback
        srx <= 1'b0;
        wr_reg(ADDR_MODEM_CTL, 8'h12);
        repeat (2) @(posedge clk);
        chk({3'h0, stx, dtr_n, rts_n, u1_n, u2_n}, 8'h1f);
        chk({7'h0, rsi}, {7'h0, sbit});
        chk({7'h0, irq}, 8'h01);
        rd_reg(ADDR_MODEM_STAT, v);
        chk({4'h0, v[7:4]}, 8'h01);
        wr_reg(ADDR_MODEM_CTL, 8'h1d);
        rd_reg(ADDR_MODEM_STAT, v);
        chk({4'h0, v[7:4]}, 8'h0e);
        chk({7'h0, irq}, 8'h00);
        wr_reg(ADDR_MODEM_CTL, 8'h00);
        end_sim();
    end
endmodule : ulms_top_tb
`default_nettype wire
